// ---- hdl/sqp_core.sv ----
/*
 * program sequencer, return stack, data addressing, index register and the
 * sixteen output and configuration latches of a 4-bit sensor processor.
 * assumes an outside decoder presents op_i, stable during the last phase of
 * each instruction, and that core_clk_i is the oscillator.
 */
`timescale 1ns/1ps
`include "sqp_cfg.svh"

module sqp_core
    import sqp_pkg::*;
(
    input  wire logic          core_clk_i,
    input  wire logic          rst_n_i,
    input  wire sqp_op_t       op_i,
    input  wire logic          sensor_supply_on_i,
    output logic               exec_o,
    output logic        [3:0]  rom_page_o,
    output logic        [6:0]  rom_pc_o,
    output logic        [15:0] page_select_o,
    output logic               status_o,
    output logic        [3:0]  index_o,
    output logic               direct_bank_o,
    output logic               ram_hit_o,
    output logic        [3:0]  ram_rdata_o,
    output logic        [7:0]  general_out_o,
    output logic               port_output_o,
    output logic               adc_battery_o,
    output logic        [1:0]  adc_input_o,
    output logic               timer_fast_o,
    output logic               current_source_on_o,
    output logic               wake_edge_falling_o,
    output logic               char_msb_o,
    output logic               io_wake_enable_o
);

    // ======================================================================
    // instruction phase counter
    sqp_phase_t phase_reg;
    sqp_phase_t phase_next;
    logic       exec_reg;
    logic       exec_next;
    logic       last_phase;

    assign last_phase = (phase_reg == SQP_PH5);

    // six clocks per instruction whatever the instruction is
    always_comb begin
        unique case (phase_reg)
            SQP_PH0: phase_next = SQP_PH1;
            SQP_PH1: phase_next = SQP_PH2;
            SQP_PH2: phase_next = SQP_PH3;
            SQP_PH3: phase_next = SQP_PH4;
            SQP_PH4: phase_next = SQP_PH5;
            SQP_PH5: phase_next = SQP_PH0;
            default: phase_next = SQP_PH0;
        endcase
        exec_next = (phase_next == SQP_PH5);
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_reg <= SQP_PH0;
            exec_reg  <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            exec_reg  <= exec_next;
        end
    end

    // ======================================================================
    // sequencer: pc, page, buffer, status, return stack
    logic [6:0]  pc_reg;
    logic [6:0]  pc_next;
    logic [6:0]  pc_step;
    logic [3:0]  page_address_reg;
    logic [3:0]  page_address_next;
    logic [3:0]  page_buffer_reg;
    logic [3:0]  page_buffer_next;
    logic [15:0] page_sel_reg;
    logic [15:0] page_sel_next;
    logic        status_reg;
    logic        status_next;
    sqp_ret_t    stack_reg [0:2];
    sqp_ret_t    stack_next [0:2];
    logic        jump_taken;
    logic        call_taken;
    sqp_ret_t    return_top;
    logic [3:0]  index_reg;
    logic [3:0]  index_next;

    // the 3F and 7F patches bring the all-ones state into the cycle
    always_comb begin
        if (pc_reg == `SQP_PC_HALF) begin
            pc_step = `SQP_PC_FULL;
        end else if (pc_reg == `SQP_PC_FULL) begin
            pc_step = `SQP_PC_AFTER_FULL;
        end else begin
            pc_step = {pc_reg[5:0], ~(pc_reg[6] ^ pc_reg[5])};
        end
    end

    assign jump_taken = status_reg & (op_i.branch_op | op_i.call_op);
    assign call_taken = status_reg & op_i.call_op;
    assign return_top = stack_reg[0];

    // next sequencer state, only moved in the last phase
    always_comb begin
        pc_next           = pc_reg;
        page_address_next = page_address_reg;
        page_buffer_next  = page_buffer_reg;
        status_next       = status_reg;
        for (int i = 0; i < 3; i++) begin
            stack_next[i] = stack_reg[i];
        end
        if (last_phase) begin
            if (op_i.return_op) begin
                pc_next           = return_top.pc;
                page_address_next = return_top.page;
                stack_next[0]     = stack_reg[1];
                stack_next[1]     = stack_reg[2];
            end else if (jump_taken) begin
                pc_next           = op_i.target;
                page_address_next = page_buffer_reg;
            end else begin
                pc_next = pc_step;
            end
            // the oldest level is lost on a fourth nested call
            if (call_taken) begin
                stack_next[0] = '{page: page_address_reg, pc: pc_step};
                stack_next[1] = stack_reg[0];
                stack_next[2] = stack_reg[1];
            end
            if (op_i.load_page_op) begin
                page_buffer_next = op_i.operand;
            end
            // status lives one instruction, then comes back to one
            if (op_i.dec_index_op) begin
                status_next = (index_reg != `SQP_Y_MIN) & ~op_i.status_clear;
            end else if (op_i.inc_index_op) begin
                status_next = (index_reg == `SQP_Y_MAX) & ~op_i.status_clear;
            end else begin
                status_next = ~op_i.status_clear;
            end
        end
        page_sel_next = 16'h0001 << page_address_next;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_reg           <= `SQP_INIT_PC;
            page_address_reg <= `SQP_INIT_PAGE;
            page_buffer_reg  <= `SQP_INIT_PAGE;
            page_sel_reg     <= 16'h8000;
            status_reg       <= 1'b1;
            for (int i = 0; i < 3; i++) begin
                stack_reg[i] <= '0;
            end
        end else begin
            pc_reg           <= pc_next;
            page_address_reg <= page_address_next;
            page_buffer_reg  <= page_buffer_next;
            page_sel_reg     <= page_sel_next;
            status_reg       <= status_next;
            for (int i = 0; i < 3; i++) begin
                stack_reg[i] <= stack_next[i];
            end
        end
    end

    // ======================================================================
    // data addressing and index register
    logic [3:0] bank_reg;
    logic [3:0] bank_next;
    logic       dab_latch_reg;
    logic       dab_latch_next;
    logic [3:0] bank_eff;
    logic [3:0] bank_fold;
    logic       bank_hit;
    logic       ram_hit_reg;

    always_comb begin
        index_next     = index_reg;
        bank_next      = bank_reg;
        dab_latch_next = dab_latch_reg;
        if (last_phase) begin
            if (op_i.load_bank_op) begin
                bank_next      = op_i.operand;
                dab_latch_next = 1'b0;
            end else if (op_i.bank_toggle_op) begin
                dab_latch_next = ~dab_latch_reg;
            end
            if (op_i.dec_index_op) begin
                index_next = index_reg - 4'h1;
            end else if (op_i.inc_index_op) begin
                index_next = index_reg + 4'h1;
            end else if (op_i.load_index_op) begin
                index_next = op_i.operand;
            end
        end
    end

    // the latch overrides the bank register; both aliases share storage
    assign bank_eff  = dab_latch_reg ? `SQP_DAB_BANK : bank_reg;
    assign bank_fold = (bank_eff == `SQP_DAB_BANK) ? `SQP_DAB_ALIAS : bank_eff;

    // unpopulated codes read back but never store
    always_comb begin
        unique case (bank_eff)
            4'h1, 4'h2, 4'h3, 4'h4, 4'h7: bank_hit = 1'b1;
            4'h9, 4'hA, 4'hB, 4'hC, 4'hF: bank_hit = 1'b1;
            default:                      bank_hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            index_reg     <= `SQP_INIT_Y;
            bank_reg      <= `SQP_INIT_BANK;
            dab_latch_reg <= 1'b0;
            ram_hit_reg   <= 1'b0;
        end else begin
            index_reg     <= index_next;
            bank_reg      <= bank_next;
            dab_latch_reg <= dab_latch_next;
            ram_hit_reg   <= bank_hit;
        end
    end

    sqp_ram u_ram (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .we_i       (last_phase & op_i.ram_write & bank_hit),
        .addr_i     ({bank_fold, index_reg}),
        .wdata_i    (op_i.ram_wdata),
        .rdata_o    (ram_rdata_o)
    );

    // ======================================================================
    // output and configuration latches
    logic [15:0] latch_reg;
    logic [15:0] latch_next;
    logic        current_src_reg;
    logic        current_src_next;

    // low-power modes have no path here, so contents hold through them
    always_comb begin
        latch_next = latch_reg;
        if (last_phase && op_i.set_latch_op) begin
            latch_next[index_reg] = 1'b1;
        end else if (last_phase && op_i.clear_latch_op) begin
            latch_next[index_reg] = 1'b0;
        end
        current_src_next = latch_next[`SQP_LATCH_CURRENT] & sensor_supply_on_i;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            latch_reg       <= `SQP_INIT_LATCHES;
            current_src_reg <= 1'b0;
        end else begin
            latch_reg       <= latch_next;
            current_src_reg <= current_src_next;
        end
    end

    // ======================================================================
    // port mapping, all from flops, io_wake_enable_o through an inverter
    assign exec_o              = exec_reg;
    assign rom_page_o          = page_address_reg;
    assign rom_pc_o            = pc_reg;
    assign page_select_o       = page_sel_reg;
    assign status_o            = status_reg;
    assign index_o             = index_reg;
    assign direct_bank_o       = dab_latch_reg;
    assign ram_hit_o           = ram_hit_reg;
    assign general_out_o       = latch_reg[7:0];
    assign port_output_o       = latch_reg[`SQP_LATCH_PORT_DIR_I];
    assign adc_battery_o       = latch_reg[`SQP_LATCH_ADC_LOW];
    assign adc_input_o         = latch_reg[`SQP_LATCH_ADC_HIGH -: 2];
    assign timer_fast_o        = latch_reg[`SQP_LATCH_TIMER];
    assign current_source_on_o = current_src_reg;
    assign wake_edge_falling_o = latch_reg[`SQP_LATCH_WAKE_EDGE];
    assign char_msb_o          = latch_reg[`SQP_LATCH_WAKE_EDGE];
    assign io_wake_enable_o    = ~latch_reg[`SQP_LATCH_IO_WAKE];

    // ======================================================================
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_quiet_five;
        !exec_reg [*5];
    endsequence

    property p_six_cycles;
        exec_reg |=> s_quiet_five ##1 exec_reg;
    endproperty
    a_six_cycles: assert property (p_six_cycles) else $error("instruction not six clocks");

    property p_seq_step;
        last_phase && !op_i.return_op && !jump_taken |=> pc_reg == $past(pc_step) &&
            page_address_reg == $past(page_address_reg);
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("pc did not step in page");

    property p_page_load;
        last_phase && op_i.load_page_op && !jump_taken && !op_i.return_op |=>
            page_buffer_reg == $past(op_i.operand) && page_address_reg == $past(page_address_reg);
    endproperty
    a_page_load: assert property (p_page_load) else $error("page load reached page address");

    property p_branch;
        last_phase && op_i.branch_op && status_reg && !op_i.return_op |=>
            pc_reg == $past(op_i.target) && page_address_reg == $past(page_buffer_reg);
    endproperty
    a_branch: assert property (p_branch) else $error("taken branch wrong target");

    property p_status_rest;
        last_phase && !op_i.status_clear && !op_i.dec_index_op && !op_i.inc_index_op |=>
            status_reg [*6];
    endproperty
    a_status_rest: assert property (p_status_rest) else $error("status did not rest at one");

    property p_call_push;
        last_phase && call_taken && !op_i.return_op |=>
            stack_reg[0].pc == $past(pc_step) && stack_reg[0].page == $past(page_address_reg) &&
            stack_reg[1] == $past(stack_reg[0]);
    endproperty
    a_call_push: assert property (p_call_push) else $error("call did not push return");

    property p_return_pop;
        last_phase && op_i.return_op && !call_taken |=>
            pc_reg == $past(stack_reg[0].pc) && page_address_reg == $past(stack_reg[0].page) &&
            stack_reg[0] == $past(stack_reg[1]);
    endproperty
    a_return_pop: assert property (p_return_pop) else $error("return did not pop");

    property p_bank_latch;
        last_phase && op_i.bank_toggle_op && !op_i.load_bank_op |=> dab_latch_reg != $past(dab_latch_reg);
    endproperty
    a_bank_latch: assert property (p_bank_latch) else $error("bank latch did not toggle");

    property p_dec_status;
        last_phase && op_i.dec_index_op && !op_i.status_clear |=>
            status_reg == ($past(index_reg) != `SQP_Y_MIN) && index_reg == $past(index_reg) - 4'h1;
    endproperty
    a_dec_status: assert property (p_dec_status) else $error("decrement status wrong");

    property p_set_latch;
        last_phase && op_i.set_latch_op |=> latch_reg[$past(index_reg)];
    endproperty
    a_set_latch: assert property (p_set_latch) else $error("addressed latch not set");

endmodule : sqp_core

// ---- hdl/sqp_ram.sv ----
/*
 * data nibble store: sixteen banks of sixteen nibbles, one write port,
 * one registered read port.
 * assumes the caller folds bank aliases before the address reaches it.
 */
`timescale 1ns/1ps

module sqp_ram (
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       we_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [3:0] wdata_i,
    output logic      [3:0] rdata_o
);

    logic [3:0] mem_reg [0:255];
    logic [3:0] rdata_reg;

    // ======================================================================
    // array write; no reset, contents survive like real cells
    always_ff @(posedge core_clk_i) begin
        if (we_i) begin
            mem_reg[addr_i] <= wdata_i;
        end
    end

    // registered read keeps the output straight from a flop
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 4'h0;
        end else begin
            rdata_reg <= mem_reg[addr_i];
        end
    end

    assign rdata_o = rdata_reg;

endmodule : sqp_ram

// ---- pkg/sqp_cfg.svh ----
/*
 * constants of the program sequencer and latch core: reset values, counter
 * landmarks, bank codes and latch indices.
 * assumes it is included by bare name wherever a constant is needed.
 */
`ifndef SQP_CFG_SVH
`define SQP_CFG_SVH

// ==========================================================================
// instruction timing
`define SQP_CYCLES_PER_INSTR 3'h6
`define SQP_PHASE_LAST       3'h5

// ==========================================================================
// reset values
`define SQP_INIT_PC          7'h00
`define SQP_INIT_PAGE        4'hF
`define SQP_INIT_LATCHES     16'h0000
`define SQP_INIT_Y           4'h0
`define SQP_INIT_BANK        4'h0

// ==========================================================================
// program counter landmarks
`define SQP_PC_HALF          7'h3F
`define SQP_PC_FULL          7'h7F
`define SQP_PC_AFTER_FULL    7'h7E

// ==========================================================================
// bank codes, index limits and latch indices
`define SQP_DAB_BANK         4'hF
`define SQP_DAB_ALIAS        4'h7
`define SQP_Y_MAX            4'hF
`define SQP_Y_MIN            4'h0
`define SQP_LATCH_PORT_DIR   4
`define SQP_LATCH_PORT_DIR_I 8
`define SQP_LATCH_ADC_LOW    9
`define SQP_LATCH_ADC_HIGH   11
`define SQP_LATCH_TIMER      12
`define SQP_LATCH_CURRENT    13
`define SQP_LATCH_WAKE_EDGE  14
`define SQP_LATCH_IO_WAKE    15

`endif

// ---- pkg/sqp_pkg.sv ----
/*
 * types of the program sequencer and latch core.
 * assumes sqp_cfg.svh sits beside it for the constants.
 */
package sqp_pkg;

    // ======================================================================
    // instruction phase within one six-cycle instruction
    typedef enum logic [2:0] {
        SQP_PH0 = 3'h0,
        SQP_PH1 = 3'h1,
        SQP_PH2 = 3'h2,
        SQP_PH3 = 3'h3,
        SQP_PH4 = 3'h4,
        SQP_PH5 = 3'h5
    } sqp_phase_t;

    // ======================================================================
    // decoded instruction strobes, valid in the last phase
    typedef struct packed {
        logic       branch_op;
        logic       call_op;
        logic       return_op;
        logic       load_page_op;
        logic       load_bank_op;
        logic       bank_toggle_op;
        logic       set_latch_op;
        logic       clear_latch_op;
        logic       dec_index_op;
        logic       inc_index_op;
        logic       load_index_op;
        logic       status_clear;
        logic       ram_write;
        logic [6:0] target;
        logic [3:0] operand;
        logic [3:0] ram_wdata;
    } sqp_op_t;

    // one return stack level
    typedef struct packed {
        logic [3:0] page;
        logic [6:0] pc;
    } sqp_ret_t;

endpackage : sqp_pkg

// ---- test/sqp_core_tb.sv ----
/*
 * self-checking bench for the sequencer and latch core: reset state, six-clock
 * instruction rhythm, pc stepping, branch, call and return, index status,
 * output latches and bank addressing.
 * assumes sqp_pkg and sqp_cfg.svh are compiled ahead and op_i is driven here.
 */
`timescale 1ns/1ps
`include "sqp_cfg.svh"

module sqp_core_tb;
    import sqp_pkg::*;

    // ======================================================================
    // signals and bookkeeping
    logic        core_clk_i;
    logic        rst_n_i;
    sqp_op_t     op_i;
    logic        sensor_supply_on_i;
    logic        exec_o, status_o, direct_bank_o, ram_hit_o, port_output_o, adc_battery_o;
    logic        timer_fast_o, current_source_on_o, wake_edge_falling_o, char_msb_o, io_wake_enable_o;
    logic [3:0]  rom_page_o, index_o, ram_rdata_o;
    logic [6:0]  rom_pc_o;
    logic [15:0] page_select_o;
    logic [7:0]  general_out_o;
    logic [1:0]  adc_input_o;
    logic [6:0]  epc;
    logic [15:0] lat;
    int          failures;
    int          num_checks;
    localparam int K_IDLE = 0, K_BR = 1, K_CALL = 2, K_RET = 3, K_PAGE = 4, K_BANK = 5, K_TGL = 6;
    localparam int K_SET = 7, K_CLR = 8, K_DEC = 9, K_INC = 10, K_LDY = 11, K_SCLR = 12, K_WR = 13;

    sqp_core dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .op_i(op_i),
        .sensor_supply_on_i(sensor_supply_on_i), .exec_o(exec_o), .rom_page_o(rom_page_o),
        .rom_pc_o(rom_pc_o), .page_select_o(page_select_o), .status_o(status_o), .index_o(index_o),
        .direct_bank_o(direct_bank_o), .ram_hit_o(ram_hit_o), .ram_rdata_o(ram_rdata_o),
        .general_out_o(general_out_o), .port_output_o(port_output_o), .adc_battery_o(adc_battery_o),
        .adc_input_o(adc_input_o), .timer_fast_o(timer_fast_o), .current_source_on_o(current_source_on_o),
        .wake_edge_falling_o(wake_edge_falling_o), .char_msb_o(char_msb_o),
        .io_wake_enable_o(io_wake_enable_o));

    // 20 MHz oscillator
    always #25 core_clk_i = ~core_clk_i;

    // ======================================================================
    // shared tasks
    function automatic logic [6:0] nxt(input logic [6:0] p);
        if (p == 7'h3F) return 7'h7F;
        if (p == 7'h7F) return 7'h7E;
        return {p[5:0], ~(p[6] ^ p[5])};
    endfunction : nxt

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // present one instruction, hold it over the exec edge, return once it landed
    task automatic run(input int k, input logic [6:0] v);
        sqp_op_t o;
        int      n;
        o = '0;
        n = 0;
        o.target = v;
        o.operand = v[3:0];
        o.ram_wdata = v[3:0];
        case (k)
            K_BR:   o.branch_op = 1'b1;
            K_CALL: o.call_op = 1'b1;
            K_RET:  o.return_op = 1'b1;
            K_PAGE: o.load_page_op = 1'b1;
            K_BANK: o.load_bank_op = 1'b1;
            K_TGL:  o.bank_toggle_op = 1'b1;
            K_SET:  o.set_latch_op = 1'b1;
            K_CLR:  o.clear_latch_op = 1'b1;
            K_DEC:  o.dec_index_op = 1'b1;
            K_INC:  o.inc_index_op = 1'b1;
            K_LDY:  o.load_index_op = 1'b1;
            K_SCLR: o.status_clear = 1'b1;
            K_WR:   o.ram_write = 1'b1;
            default: ;
        endcase
        @(posedge core_clk_i);
        op_i <= o;
        @(negedge core_clk_i);
        while (exec_o !== 1'b1 && n < 8) begin
            @(negedge core_clk_i);
            n++;
        end
        if (n == 8) failures++;
        @(posedge core_clk_i);
        op_i <= '0;
        @(negedge core_clk_i);
        epc = nxt(epc);
    endtask : run

    // latch outputs gathered in latch order, current source left out
    task automatic chk_lat();
        chk({~io_wake_enable_o, wake_edge_falling_o, timer_fast_o, adc_input_o, adc_battery_o,
             port_output_o, general_out_o}, {lat[15:14], lat[12:0]});
        chk(char_msb_o, lat[14]);
    endtask : chk_lat

    // ======================================================================
    // scenarios
    task automatic t_reset();
        chk(rom_pc_o, `SQP_INIT_PC);
        chk(rom_page_o, `SQP_INIT_PAGE);
        chk(page_select_o, 16'h8000);
        chk({status_o, direct_bank_o, index_o}, 6'h20);
        chk_lat();
    endtask : t_reset

    task automatic t_pcwalk();
        for (int i = 0; i < 128; i++) begin
            run(K_IDLE, 7'h00);
            chk(rom_pc_o, epc);
        end
        chk(rom_pc_o, 7'h00);
    endtask : t_pcwalk

    task automatic t_period();
        int n;
        n = 1;
        while (exec_o !== 1'b1 && n < 8) @(negedge core_clk_i);
        @(negedge core_clk_i);
        while (exec_o !== 1'b1 && n < 12) begin
            @(negedge core_clk_i);
            n++;
        end
        chk(n, 6);
        epc = nxt(epc);
    endtask : t_period

    task automatic t_branch();
        run(K_PAGE, 7'h03);
        chk(rom_page_o, 4'hF);
        run(K_BR, 7'h12);
        epc = 7'h12;
        chk({rom_page_o, rom_pc_o}, {4'h3, 7'h12});
        chk(page_select_o, 16'h0008);
        run(K_SCLR, 7'h00);
        chk(status_o, 1'b0);
        run(K_BR, 7'h55);
        chk({rom_page_o, rom_pc_o}, {4'h3, epc});
        chk(status_o, 1'b1);
    endtask : t_branch

    task automatic t_call();
        logic [6:0] r1, r2;
        run(K_PAGE, 7'h06);
        r1 = nxt(epc);
        run(K_CALL, 7'h20);
        epc = 7'h20;
        chk({rom_page_o, rom_pc_o}, {4'h6, 7'h20});
        run(K_PAGE, 7'h09);
        r2 = nxt(epc);
        run(K_CALL, 7'h30);
        epc = 7'h30;
        chk({rom_page_o, rom_pc_o}, {4'h9, 7'h30});
        run(K_SCLR, 7'h00);
        run(K_CALL, 7'h40);
        chk({rom_page_o, rom_pc_o}, {4'h9, epc});
        run(K_RET, 7'h00);
        epc = r2;
        chk({rom_page_o, rom_pc_o}, {4'h6, r2});
        run(K_RET, 7'h00);
        epc = r1;
        chk({rom_page_o, rom_pc_o}, {4'h3, r1});
    endtask : t_call

    task automatic t_index();
        run(K_LDY, 7'h00);
        run(K_DEC, 7'h00);
        chk({status_o, index_o}, 5'h0F);
        run(K_DEC, 7'h00);
        chk({status_o, index_o}, 5'h1E);
        run(K_LDY, 7'h0F);
        run(K_INC, 7'h00);
        chk({status_o, index_o}, 5'h10);
        run(K_INC, 7'h00);
        chk({status_o, index_o}, 5'h01);
    endtask : t_index

    task automatic t_latch();
        for (int y = 0; y < 16; y++) begin
            run(K_LDY, 7'(y));
            run(K_SET, 7'h00);
            lat[y] = 1'b1;
            chk_lat();
        end
        @(negedge core_clk_i);
        chk(current_source_on_o, 1'b1);
        @(posedge core_clk_i);
        sensor_supply_on_i <= 1'b0;
        repeat (2) @(negedge core_clk_i);
        chk(current_source_on_o, 1'b0);
        @(posedge core_clk_i);
        sensor_supply_on_i <= 1'b1;
        for (int y = 15; y >= 0; y--) begin
            run(K_LDY, 7'(y));
            run(K_CLR, 7'h00);
            lat[y] = 1'b0;
            chk_lat();
        end
        @(negedge core_clk_i);
        chk(current_source_on_o, 1'b0);
    endtask : t_latch

    task automatic t_ram();
        logic [15:0] hit;
        hit = 16'h9E9E;
        for (int b = 0; b < 16; b++) begin
            run(K_BANK, 7'(b));
            @(negedge core_clk_i);
            chk(ram_hit_o, hit[b]);
        end
        run(K_BANK, 7'h02);
        run(K_LDY, 7'h05);
        run(K_WR, 7'h0A);
        run(K_BANK, 7'h03);
        run(K_WR, 7'h05);
        run(K_BANK, 7'h07);
        run(K_WR, 7'h0C);
        run(K_BANK, 7'h02);
        @(negedge core_clk_i);
        chk(ram_rdata_o, 4'hA);
        run(K_BANK, 7'h0F);
        @(negedge core_clk_i);
        chk(ram_rdata_o, 4'hC);
        run(K_BANK, 7'h02);
        run(K_TGL, 7'h00);
        @(negedge core_clk_i);
        chk({direct_bank_o, ram_rdata_o}, 5'h1C);
        run(K_TGL, 7'h00);
        @(negedge core_clk_i);
        chk({direct_bank_o, ram_rdata_o}, 5'h0A);
        run(K_TGL, 7'h00);
        run(K_BANK, 7'h03);
        @(negedge core_clk_i);
        chk({direct_bank_o, ram_rdata_o}, 5'h05);
    endtask : t_ram

    // ======================================================================
    // main sequence and watchdog
    initial begin
        core_clk_i = 1'b0;
        rst_n_i = 1'b0;
        op_i = '0;
        sensor_supply_on_i = 1'b1;
        failures = 0;
        num_checks = 0;
        epc = 7'h00;
        lat = 16'h0000;
        repeat (16) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(negedge core_clk_i);
        t_reset();
        t_pcwalk();
        t_period();
        t_branch();
        t_call();
        t_index();
        t_latch();
        t_ram();
        test_done();
    end

    // the whole run needs some 1480 cycles; cut a hang at over twenty times that
    initial begin
        #1500000;
        failures++;
        test_done();
    end

endmodule : sqp_core_tb
